// >>> design/dch_regs.svh
// Register map, field positions, modes and filter coefficients.
`ifndef DCH_REGS_SVH
`define DCH_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DCH_ADR_MSB    7
`define DCH_CTRL_OFS   8'h00
`define DCH_STAT_OFS   8'h04
`define DCH_CNT_OFS    8'h08
`define DCH_CTRL_W     7
`define DCH_CTRL_RST   7'h00
`define DCH_MODE_MSB   4
`define DCH_WIDE_BIT   5
`define DCH_BOOST_BIT  6

// ----------------------------------------------------------------
// Link mode codes
// ----------------------------------------------------------------
`define DCH_MD_D2      5'h09
`define DCH_MD_D4_LO   5'h0A
`define DCH_MD_D4_HI   5'h0C
`define DCH_MD_C12     5'h0C
`define DCH_MD_D8_LO   5'h0D
`define DCH_MD_D8_HI   5'h0E
`define DCH_MD_D16_LO  5'h0F
`define DCH_MD_D16_HI  5'h10

// ----------------------------------------------------------------
// Data path constants
// ----------------------------------------------------------------
`define DCH_PAD4       4'h0
`define DCH_SAT_HI     16'h7FFF
`define DCH_SAT_LO     16'h8000
`define DCH_CW         20

// ----------------------------------------------------------------
// Half-band sets: outer tap first, centre as a power of two
// ----------------------------------------------------------------
`define DCH_SHORT_NH   2
`define DCH_SHORT_SH   10
`define DCH_SHORT_CF   {20'hFFFBF, 20'h00241}
`define DCH_SMALL_NH   3
`define DCH_SMALL_SH   13
`define DCH_SMALL_CF   {20'h0006D, 20'hFFCBB, 20'h012D8}
`define DCH_MED_NH     4
`define DCH_MED_SH     16
`define DCH_MED_CF     {20'hFFEB9, 20'h008B7, 20'hFDD4F, 20'h09B3E}
`define DCH_QTR_NH     5
`define DCH_QTR_SH     15
`define DCH_QTR_CF     {20'h00038, 20'hFFE6F, 20'h0063C, 20'hFEC8D, 20'h04E91}
`define DCH_FIN_NH     14
`define DCH_FIN_SH     18
`define DCH_FIN_CF     {20'hFFFDB, 20'h00076, 20'hFFEDD, 20'h00264, 20'hFFB79, \
                        20'h007EF, 20'hFF2E4, 20'h014BC, 20'hFE034, 20'h02FFC, \
                        20'hFB73C, 20'h0730F, 20'hF3039, 20'h288AB}
`define DCH_WIDE_NH    16
`define DCH_WIDE_SH    14
`define DCH_WIDE_CF    {20'hFFFF1, 20'h00017, 20'hFFFD8, 20'h00040, 20'hFFF9F, \
                        20'h0008E, 20'hFFF37, 20'h00117, 20'hFFE84, 20'h00201, \
                        20'hFFD4E, 20'h003AB, 20'hFFADF, 20'h007A4, 20'hFF2BA, \
                        20'h028A4}

`endif

// >>> design/dch_pkg.sv
// Shared types of the decimation chain.
package dch_pkg;
  typedef logic [11:0] dch_smp_t;
  typedef logic [15:0] dch_word_t;
  typedef logic [1:0]  dch_thr_t;
  typedef enum logic [1:0] {
    FMT_BYP  = 2'b00,
    FMT_REAL = 2'b01,
    FMT_CPLX = 2'b10,
    FMT_C12  = 2'b11
  } dch_fmt_t;
endpackage : dch_pkg

// >>> design/dch_halfband.sv
// Half-band decimate-by-two filter stage with symmetric taps.
`include "dch_regs.svh"
module dch_halfband #(
  parameter int                      NH   = 2,
  parameter logic [NH*`DCH_CW-1:0]   COEF = '0,
  parameter int                      CSH  = 10
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Samples in
  input  wire logic               in_vld,
  input  wire dch_pkg::dch_word_t in_dat,
  // Samples out
  output logic                    out_vld,
  output dch_pkg::dch_word_t      out_dat
);
  import dch_pkg::*;

  localparam int L  = 4 * NH - 1;
  localparam int C  = 2 * NH - 1;
  localparam int AW = 44;

  logic signed [15:0]   tap_r [L];
  logic                 phase_r;
  logic                 calc_r;
  logic signed [AW-1:0] part [NH+1];
  logic signed [AW-1:0] rnd;
  logic signed [AW-1:0] acc;
  logic                 ovf;
  dch_word_t            sat;

  // ----------------------------------------------------------------
  // Multiply-accumulate
  // ----------------------------------------------------------------
  // Centre tap is a power of two, so it costs a shift, not a multiplier.
  assign part[0] = AW'(tap_r[C]) <<< CSH;
  for (genvar k = 0; k < NH; k++) begin : g_tap
    localparam int D = 2 * (NH - k) - 1;
    logic signed [`DCH_CW-1:0] cf;
    logic signed [16:0]        pair;
    assign cf      = COEF[(NH-1-k)*`DCH_CW +: `DCH_CW];
    assign pair    = 17'(tap_r[C-D]) + 17'(tap_r[C+D]);
    assign part[k+1] = part[k] + AW'(cf * pair);
  end

  // Taps sum to twice the centre within a few counts, so one more shift gives near-unity DC gain.
  assign rnd = part[NH] + (AW'(1) <<< CSH);
  assign acc = rnd >>> (CSH + 1);
  assign ovf = !((&acc[AW-1:15]) | ~(|acc[AW-1:15]));
  assign sat = ovf ? (acc[AW-1] ? `DCH_SAT_LO : `DCH_SAT_HI) : acc[15:0];

  // ----------------------------------------------------------------
  // Delay line and decimation phase
  // ----------------------------------------------------------------
  // One result per two inputs; it leaves two cycles after the odd input.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < L; i++) tap_r[i] <= '0;
      phase_r <= 1'b0;
      calc_r  <= 1'b0;
      out_vld <= 1'b0;
      out_dat <= '0;
    end else begin
      if (in_vld) begin
        tap_r[0] <= in_dat;
        for (int i = 1; i < L; i++) tap_r[i] <= tap_r[i-1];
        phase_r <= ~phase_r;
      end
      calc_r  <= in_vld & phase_r;
      out_vld <= calc_r;
      if (calc_r) out_dat <= sat;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  half_rate_a: assert property (
    out_vld |=> !out_vld)
    else $error("Stage produced results at more than half rate.");

  odd_out_a: assert property (
    in_vld && phase_r |-> ##2 out_vld)
    else $error("Stage missed the result after an odd input.");

endmodule : dch_halfband

// >>> design/dch_decim_top.sv
// Decimation chain, output packing and register slave of the down-converter.
//
// Summary of operation
// - Factor 2 uses the final set, 4 uses quarter then final or wide final, 8 small-medium-final, 16 short-small-medium-final.
// - Each stage uses its fixed symmetric coefficient set with its power-of-two centre tap.
// - The link mode selects bypass, real by 2 (9), complex by 4 (10-12), by 8 (13-14) or by 16 (15-16).
// - Real decimate-by-2 mode delivers 15-bit real samples per channel.
// - Complex modes other than 12 deliver 15-bit I and Q with both threshold flags carried along.
// - Mode 12 delivers 12-bit complex data without flags; flags go to the overrange pins.
// - Real words hold the sample in bits 15:1, bit 0 the first flag on even and second on odd samples.
// - Complex words hold 15 bits on top, bit 0 the first flag in I and the second flag in Q.
// - Gain boost doubles the chain output (6.02 dB), otherwise the chain has unity gain.
// - Every decimating output except mode 12 carries 15 bits of resolution; mode 12 carries 12.
// - Coefficients are mirrored about the centre tap to form the full response.
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`include "dch_regs.svh"
module dch_decim_top (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // Converter samples after the mixer
  input  wire logic               smp_vld,
  input  wire dch_pkg::dch_smp_t  chan_a_i,
  input  wire dch_pkg::dch_smp_t  chan_a_q,
  input  wire dch_pkg::dch_smp_t  chan_b_i,
  input  wire dch_pkg::dch_smp_t  chan_b_q,
  // Threshold detector flags
  input  wire dch_pkg::dch_thr_t  chan_a_thr,
  input  wire dch_pkg::dch_thr_t  chan_b_thr,
  // Words to the transport layer
  output logic                    out_vld,
  output logic                    out_cplx,
  output dch_pkg::dch_word_t      out_a_w0,
  output dch_pkg::dch_word_t      out_a_w1,
  output dch_pkg::dch_word_t      out_b_w0,
  output dch_pkg::dch_word_t      out_b_w1,
  // Overrange pins
  output logic                    chan_a_overrange_pin_first,
  output logic                    chan_a_overrange_pin_second,
  output logic                    chan_b_overrange_pin_first,
  output logic                    chan_b_overrange_pin_second
);
  import dch_pkg::*;

  logic [`DCH_CTRL_W-1:0]   ctrl_r;
  logic [`DCH_CTRL_W-1:0]   ctrl_nxt;
  logic [`DCH_MODE_MSB:0]   mode;
  logic                     d2, d4, d8, d16, byp, wide, boost, cplx;
  logic [2:0]               nst;
  dch_fmt_t                 fmt;
  dch_smp_t                 smp [4];
  logic [3:0]               res_v;
  logic signed [15:0]       res [4];
  dch_word_t                word_r [4];
  logic                     out_stb;
  logic                     odd_r;
  logic [1:0]               acc_r [2];
  logic [1:0]               cur [2];
  logic [3:0]               pins_r;
  logic [15:0]              cnt_r;
  logic                     ap, wr_r, ahi, ctrl_we;
  logic [`DCH_ADR_MSB:0]    adr_r;
  logic [`DCH_ADR_MSB:0]    ra;
  logic [8:0]               stat;
  logic [31:0]              rd_val;
  logic [31:0]              hrdata_r;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign mode  = ctrl_r[`DCH_MODE_MSB:0];
  assign wide  = ctrl_r[`DCH_WIDE_BIT];
  assign boost = ctrl_r[`DCH_BOOST_BIT];
  assign d2    = mode == `DCH_MD_D2;
  assign d4    = (mode >= `DCH_MD_D4_LO) && (mode <= `DCH_MD_D4_HI);
  assign d8    = (mode >= `DCH_MD_D8_LO) && (mode <= `DCH_MD_D8_HI);
  assign d16   = (mode >= `DCH_MD_D16_LO) && (mode <= `DCH_MD_D16_HI);
  assign byp   = !(d2 | d4 | d8 | d16);
  assign cplx  = d4 | d8 | d16;
  assign nst   = {d16, d8 | d4, d8 | d2};
  assign fmt   = byp ? FMT_BYP : d2 ? FMT_REAL :
                 (mode == `DCH_MD_C12) ? FMT_C12 : FMT_CPLX;

  // Paths: 0 = A in-phase, 1 = A quadrature, 2 = B in-phase, 3 = B quadrature.
  assign smp[0] = chan_a_i;
  assign smp[1] = chan_a_q;
  assign smp[2] = chan_b_i;
  assign smp[3] = chan_b_q;

  // Flags seen since the last output word, including this cycle's.
  assign cur[0] = acc_r[0] | chan_a_thr;
  assign cur[1] = acc_r[1] | chan_b_thr;
  assign out_stb = byp ? smp_vld : res_v[0];

  // ----------------------------------------------------------------
  // Filter chains, one per path
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 4; p++) begin : g_path
    localparam bit IQ = (p % 2) == 1;
    localparam int CH = p / 2;
    dch_word_t          x, sh_d, sm_d, md_d, qt_d, fn_d, wd_d, sm_id, fn_id, wd;
    logic               sh_v, sm_v, md_v, qt_v, fn_v, wd_v, sm_iv, fn_iv, flg;
    logic signed [15:0] bst, v16;

    // Unused stages see no valid, so they hold still and cost no toggling.
    assign x     = {smp[p], `DCH_PAD4};
    assign sm_iv = d16 ? sh_v : smp_vld & d8;
    assign sm_id = d16 ? sh_d : x;
    assign fn_iv = d2 ? smp_vld & !IQ : d4 ? qt_v & !wide : md_v;
    assign fn_id = d2 ? x : d4 ? qt_d : md_d;

    // Coefficient sets are fixed per stage.
    dch_halfband #(.NH(`DCH_SHORT_NH), .COEF(`DCH_SHORT_CF), .CSH(`DCH_SHORT_SH)) u_sh (
      .clk(clk), .rst_n(rst_n), .in_vld(smp_vld & d16), .in_dat(x),
      .out_vld(sh_v), .out_dat(sh_d));
    dch_halfband #(.NH(`DCH_SMALL_NH), .COEF(`DCH_SMALL_CF), .CSH(`DCH_SMALL_SH)) u_sm (
      .clk(clk), .rst_n(rst_n), .in_vld(sm_iv), .in_dat(sm_id),
      .out_vld(sm_v), .out_dat(sm_d));
    dch_halfband #(.NH(`DCH_MED_NH), .COEF(`DCH_MED_CF), .CSH(`DCH_MED_SH)) u_md (
      .clk(clk), .rst_n(rst_n), .in_vld(sm_v), .in_dat(sm_d),
      .out_vld(md_v), .out_dat(md_d));
    dch_halfband #(.NH(`DCH_QTR_NH), .COEF(`DCH_QTR_CF), .CSH(`DCH_QTR_SH)) u_qt (
      .clk(clk), .rst_n(rst_n), .in_vld(smp_vld & d4), .in_dat(x),
      .out_vld(qt_v), .out_dat(qt_d));
    dch_halfband #(.NH(`DCH_FIN_NH), .COEF(`DCH_FIN_CF), .CSH(`DCH_FIN_SH)) u_fn (
      .clk(clk), .rst_n(rst_n), .in_vld(fn_iv), .in_dat(fn_id),
      .out_vld(fn_v), .out_dat(fn_d));
    dch_halfband #(.NH(`DCH_WIDE_NH), .COEF(`DCH_WIDE_CF), .CSH(`DCH_WIDE_SH)) u_wd (
      .clk(clk), .rst_n(rst_n), .in_vld(qt_v & d4 & wide), .in_dat(qt_d),
      .out_vld(wd_v), .out_dat(wd_d));

    assign res_v[p] = (d4 & wide) ? wd_v : fn_v;
    assign res[p]   = (d4 & wide) ? wd_d : fn_d;

    // Boost doubles the result; saturating avoids wrap when it clips.
    assign bst = (res[p][15] != res[p][14]) ? (res[p][15] ? `DCH_SAT_LO : `DCH_SAT_HI)
                                            : {res[p][14:0], 1'b0};
    assign v16 = boost ? bst : res[p];
    assign flg = (fmt == FMT_REAL) ? cur[CH][odd_r] : cur[CH][IQ];

    // Word packing per output format.
    always_comb begin
      case (fmt)
        FMT_BYP:  wd = IQ ? '0 : {smp[p], `DCH_PAD4};
        FMT_REAL: wd = IQ ? '0 : {v16[15:1], flg};
        FMT_CPLX: wd = {v16[15:1], flg};
        FMT_C12:  wd = {v16[15:4], `DCH_PAD4};
        default:  wd = '0;
      endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) word_r[p] <= '0;
      else if (out_stb) word_r[p] <= wd;
    end
  end

  assign out_a_w0 = word_r[0];
  assign out_a_w1 = word_r[1];
  assign out_b_w0 = word_r[2];
  assign out_b_w1 = word_r[3];
  assign {chan_b_overrange_pin_second, chan_b_overrange_pin_first,
          chan_a_overrange_pin_second, chan_a_overrange_pin_first} = pins_r;

  // ----------------------------------------------------------------
  // Output strobe, sample parity, flag capture
  // ----------------------------------------------------------------
  // A flag raised in the strobe cycle goes into that strobe's pins, so none is lost.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_vld  <= 1'b0;
      out_cplx <= 1'b0;
      odd_r    <= 1'b0;
      acc_r[0] <= '0;
      acc_r[1] <= '0;
      pins_r   <= '0;
      cnt_r    <= '0;
    end else begin
      out_vld  <= out_stb;
      if (out_stb) out_cplx <= cplx;
      odd_r    <= (fmt != FMT_REAL) ? 1'b0 : odd_r ^ out_stb;
      acc_r[0] <= out_stb ? '0 : cur[0];
      acc_r[1] <= out_stb ? '0 : cur[1];
      if (out_stb) pins_r <= {cur[1], cur[0]};
      if (out_stb) cnt_r <= cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Always ready and OKAY; reads are sampled in the address phase and
  // see a write still in its data phase, so write-then-read is coherent.
  assign ap      = hsel & hready & htrans[1];
  assign ahi     = ~|haddr[31:`DCH_ADR_MSB+1];
  assign ra      = haddr[`DCH_ADR_MSB:0];
  assign ctrl_we = wr_r && (adr_r == `DCH_CTRL_OFS);
  assign ctrl_nxt = ctrl_we ? hwdata[`DCH_CTRL_W-1:0] : ctrl_r;
  assign stat    = {pins_r, odd_r, cplx, nst};
  assign rd_val  = !ahi ? '0 :
                   (ra == `DCH_CTRL_OFS) ? 32'(ctrl_nxt) :
                   (ra == `DCH_STAT_OFS) ? 32'(stat) :
                   (ra == `DCH_CNT_OFS)  ? 32'(cnt_r) : '0;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r     <= 1'b0;
      adr_r    <= '0;
      ctrl_r   <= `DCH_CTRL_RST;
      hrdata_r <= '0;
    end else begin
      wr_r     <= ap & hwrite & ahi;
      adr_r    <= ra;
      ctrl_r   <= ctrl_nxt;
      hrdata_r <= (ap & !hwrite) ? rd_val : '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  bypass_pass_a: assert property (
    byp && smp_vld |=> out_vld && out_a_w0 == {$past(chan_a_i), `DCH_PAD4})
    else $error("Bypass sample was not passed through.");

  real_flag_a: assert property (
    out_vld && $past(fmt == FMT_REAL) |-> out_a_w0[0] ==
      ($past(odd_r) ? chan_a_overrange_pin_second : chan_a_overrange_pin_first))
    else $error("Real word bit 0 carries the wrong flag.");

  real_q_zero_a: assert property (
    out_vld && $past(fmt == FMT_REAL) |-> out_a_w1 == '0 && out_b_w1 == '0 && !out_cplx)
    else $error("Real mode put data in the second words.");

  cplx_flag_a: assert property (
    out_vld && $past(fmt == FMT_CPLX) |-> out_b_w0[0] == chan_b_overrange_pin_first
      && out_b_w1[0] == chan_b_overrange_pin_second && out_cplx)
    else $error("Complex words carry the wrong flags.");

  c12_noflag_a: assert property (
    out_stb && fmt == FMT_C12 |=> out_a_w0[3:0] == `DCH_PAD4 && out_a_w1[3:0] == `DCH_PAD4
      && chan_a_overrange_pin_first == $past(cur[0][0]))
    else $error("Twelve-bit mode embedded flags or lost a pin flag.");

  boost_gain_a: assert property (
    out_stb && boost && fmt == FMT_CPLX && res[0][15] == res[0][14]
      |=> out_a_w0[15:1] == $past(res[0][14:0]))
    else $error("Boosted output is not twice the chain result.");

  unity_gain_a: assert property (
    out_stb && !boost && fmt == FMT_CPLX |=> out_a_w0[15:1] == $past(res[0][15:1]))
    else $error("Unboosted output is not the 15-bit chain result.");

  chain_sel_a: assert property (
    smp_vld && d4 && wide |-> !g_path[0].fn_iv && !g_path[0].sm_iv)
    else $error("Wide quarter mode fed an unused stage.");

  ctrl_write_a: assert property (
    ctrl_we |=> mode == $past(hwdata[`DCH_MODE_MSB:0]))
    else $error("Link mode write did not reach the control register.");

  dec_rate_a: assert property (
    out_stb && !byp ##1 $stable(ctrl_r) |-> !out_stb)
    else $error("Decimated output came at more than half rate.");

  pin_set_a: assert property (
    out_stb && chan_a_thr[0] |=> chan_a_overrange_pin_first)
    else $error("A flag raised in the strobe cycle was lost.");

  real_parity_a: assert property (
    out_stb && fmt == FMT_REAL |=> odd_r != $past(odd_r))
    else $error("Real sample parity did not alternate.");

  rdata_idle_a: assert property (
    !(ap && !hwrite) |=> hrdata == '0)
    else $error("Read data stood outside its data phase.");

  // Twelve-bit mode and bypass are the only formats that keep flags off the words.
  c12_cov: cover property (fmt == FMT_C12 && out_stb);
  bypass_cov: cover property (byp && smp_vld ##1 out_vld);
  real_cov: cover property (out_vld && $past(fmt == FMT_REAL) ##[1:4] out_vld);
  d16_cov: cover property (d16 && out_stb);
  wide_cov: cover property (d4 && wide && out_stb);

endmodule : dch_decim_top

// >>> verif/dch_xport_model.sv
// Transport-layer sink model that latches the packed words of every output strobe.
module dch_xport_model (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Words from the decimation chain
  input  wire logic               out_vld,
  input  wire dch_pkg::dch_word_t out_a_w0,
  input  wire dch_pkg::dch_word_t out_a_w1,
  input  wire dch_pkg::dch_word_t out_b_w0,
  input  wire dch_pkg::dch_word_t out_b_w1,
  // Captured words and strobe count
  output logic [63:0]             cur_r,
  output logic [63:0]             prev_r,
  output logic [15:0]             cnt_r
);
  timeunit 1ns;
  timeprecision 1ps;
  import dch_pkg::*;

  // The transport layer has no back-pressure, so every strobe is taken as it comes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r  <= 64'h0;
      prev_r <= 64'h0;
      cnt_r  <= 16'h0;
    end else if (out_vld) begin
      prev_r <= cur_r;
      cur_r  <= {out_a_w0, out_a_w1, out_b_w0, out_b_w1};
      cnt_r  <= cnt_r + 16'h1;
    end
  end
endmodule : dch_xport_model

// >>> verif/tb.sv
// Self-checking testbench of the decimation chain with its register slave.
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dch_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, smp_vld, out_vld, out_cplx;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  dch_smp_t    a_i, a_q, b_i, b_q;
  dch_thr_t    a_thr, b_thr;
  dch_word_t   a0, a1, b0, b1;
  logic        pa0, pa1, pb0, pb1;
  logic [63:0] cur, prev;
  logic [15:0] cnt;
  int          n_errors, check_count;

  dch_decim_top u_dch_decim_top (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .smp_vld(smp_vld),
    .chan_a_i(a_i), .chan_a_q(a_q), .chan_b_i(b_i), .chan_b_q(b_q), .chan_a_thr(a_thr),
    .chan_b_thr(b_thr), .out_vld(out_vld), .out_cplx(out_cplx), .out_a_w0(a0),
    .out_a_w1(a1), .out_b_w0(b0), .out_b_w1(b1), .chan_a_overrange_pin_first(pa0),
    .chan_a_overrange_pin_second(pa1), .chan_b_overrange_pin_first(pb0),
    .chan_b_overrange_pin_second(pb1));

  dch_xport_model u_dch_xport_model (.clk(clk), .rst_n(rst_n), .out_vld(out_vld),
    .out_a_w0(a0), .out_a_w1(a1), .out_b_w0(b0), .out_b_w1(b1), .cur_r(cur), .prev_r(prev),
    .cnt_r(cnt));

  // ----------------------------------------------------------------
  // Bus and stream tasks
  // ----------------------------------------------------------------
  // The slave is always ready and never stretches a phase, yet every phase still waits for hready under a bound.
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    // A phase that never completes counts against the run.
    if (hreadyout !== 1'b1) n_errors++;
  endtask : wait_rdy

  task automatic ahb(input logic wr, input logic [31:0] adr, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= adr;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wr ? wd : 32'h0;
    wait_rdy();
    rd = hrdata;
  endtask : ahb

  task automatic feed(input int n, input dch_smp_t si, input dch_smp_t sq);
    repeat (n) begin
      smp_vld <= 1'b1;
      {a_i, b_i, a_q, b_q} <= {si, si, sq, sq};
      @(posedge clk);
    end
    smp_vld <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : feed

  task automatic reset_dut;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : reset_dut

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, unmapped and read-only places, then one bypassed sample.
  task automatic t_bypass;
    @(posedge clk);
    ahb(1'b0, 32'h0, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'b1, 32'h4, 32'hFFFF);
    ahb(1'b0, 32'hC, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'b1, 32'h0, 32'h11);
    ahb(1'b0, 32'h4, 32'h0);
    `CHK({rd[3:0], hresp, hreadyout}, 6'h01)
    feed(1, 12'hABC, 12'h123);
    `CHK({cur, cnt, out_cplx}, {16'hABC0, 16'h0, 16'hABC0, 16'h0, 16'h1, 1'b0})
  endtask : t_bypass

  // A constant input settles to a known value (twice it with boost), so the last words are known exactly.
  task automatic t_mode(input logic [4:0] md, input logic wd, input logic bs);
    int n;
    logic [15:0] bi, bq;
    n  = (md == 5'h09) ? 1 : (md <= 5'h0C) ? 2 : (md <= 5'h0E) ? 3 : 4;
    bi = bs ? 16'h2000 : 16'h1000;
    bq = bs ? 16'hE000 : 16'hF000;
    // The wide final set sums twelve short of twice its centre, so DC settles a little low.
    if (wd && md >= 5'h0A && md <= 5'h0B) begin
      bi = bs ? 16'h1FFE : 16'h0FFE;
      bq = bs ? 16'hE004 : 16'hF002;
    end
    reset_dut();
    ahb(1'b1, 32'h0, {25'h0, bs, wd, md});
    ahb(1'b0, 32'h0, 32'h0);
    `CHK(rd, {25'h0, bs, wd, md})
    feed(64 << n, 12'h100, 12'hF00);
    `CHK(cnt, 16'd64)
    ahb(1'b0, 32'h8, 32'h0);
    `CHK(rd[15:0], 16'd64)
    ahb(1'b0, 32'h4, 32'h0);
    `CHK(rd[8:0] & 9'h1EF, {4'b1001, 1'b0, md != 5'h09, 3'(n)})
    `CHK({pa0, pa1, pb0, pb1, out_cplx}, {4'b1001, md != 5'h09})
    if (md == 5'h09) begin
      `CHK({cur, prev}, {bi, 16'h0, bi | 16'h1, 16'h0, bi | 16'h1, 16'h0, bi, 16'h0})
    end else if (md == 5'h0C) begin
      `CHK(cur, {bi, bq, bi, bq})
    end else begin
      `CHK(cur, {bi | 16'h1, bq, bi, bq | 16'h1})
    end
  endtask : t_mode

  // ----------------------------------------------------------------
  // Clock, sequence, watchdog and verdict
  // ----------------------------------------------------------------
  // Free-running 125 MHz device clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test;
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Every mode is run from a fresh reset so the even/odd phase starts known.
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, smp_vld} = '0;
    {a_i, a_q, b_i, b_q} = '0;
    a_thr = 2'b01;
    b_thr = 2'b10;
    hsize = 3'b010;
    n_errors = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_bypass();
    for (int m = 9; m <= 16; m++) begin
      t_mode(5'(m), 1'b0, 1'b0);
    end
    t_mode(5'h0A, 1'b1, 1'b0);
    t_mode(5'h09, 1'b0, 1'b1);
    t_mode(5'h0F, 1'b0, 1'b1);
    stop_test();
  end

  // A hang ends the run through the same verdict.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule : tb
